// ---- src/rfctl_consts.svh ----
`ifndef RFCTL_CONSTS_SVH
`define RFCTL_CONSTS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RFCTL_ADDR_CMD        8'h04
`define RFCTL_ADDR_SOFREQ     8'h0C
`define RFCTL_ADDR_RXMODE     8'h10
`define RFCTL_ADDR_TXCTRL     8'h14
`define RFCTL_ADDR_STATUS     8'h18

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RFCTL_TXCTRL_RESET    8'h80
`define RFCTL_RXMODE_RESET    8'h00

// ----------------------------------------
// Antenna driver control field positions
// ----------------------------------------
`define RFCTL_TX_INV_ON_LO    6
`define RFCTL_TX_INV_OFF_LO   4
`define RFCTL_TX_CW_B         3
`define RFCTL_TX_GUARD        2
`define RFCTL_TX_EN_B         1
`define RFCTL_TX_EN_A         0

// ----------------------------------------
// Receive mode field positions and codes
// ----------------------------------------
`define RFCTL_RX_SUPPRESS     3
`define RFCTL_RX_MULTI        2
`define RFCTL_FRM_TYPE_A      2'h0
`define RFCTL_FRM_ACTIVE      2'h1
`define RFCTL_FRM_PASSIVE     2'h2
`define RFCTL_FRM_TYPE_B      2'h3
`define RFCTL_SHORT_BITS      8'h04

// ----------------------------------------
// Commands and bus responses
// ----------------------------------------
`define RFCTL_CMD_IDLE        4'h0
`define RFCTL_CMD_RECEIVE     4'h8
`define RFCTL_CMD_TRANSCEIVE  4'hC
`define RFCTL_RESP_OKAY       2'h0
`define RFCTL_RESP_SLVERR     2'h2

`endif

// ---- src/rfctl_pkg.sv ----
package rfctl_pkg;

  // ----------------------------------------
  // Whole state of the control block
  // ----------------------------------------
  typedef struct packed {
    logic       awHeld;        // Write address captured
    logic [7:0] awAddr;        // Captured write address
    logic       wHeld;         // Write data captured
    logic [7:0] wData;         // Captured low data byte
    logic       wStrb0;        // Captured lane 0 strobe
    logic       bValid;        // Write response pending
    logic [1:0] bResp;         // Write response code
    logic       rValid;        // Read response pending
    logic [7:0] rData;         // Read data byte
    logic [1:0] rResp;         // Read response code
    logic [7:0] txCtrl;        // Antenna driver control
    logic [7:0] rxMode;        // Receive mode control
    logic       sofReq;        // Start of frame required
    logic [3:0] command;       // Current command
    logic       rxActive;      // Receiver enabled
    logic       fieldMeta;     // Field detect, first stage
    logic       fieldSync;     // Field detect, synchronised
    logic       frameReport;   // Frame accepted pulse
    logic       frameDiscard;  // Frame dropped pulse
    logic       appendValid;   // Error byte pulse
    logic [7:0] appendByte;    // Appended error byte
    logic [1:0] decoderSel;    // Decoder choice
  } rfctl_state_t;

  // ----------------------------------------
  // State of one driver pin stage
  // ----------------------------------------
  typedef struct packed {
    logic pin;                 // Registered pin level
  } rfctl_pin_t;

endpackage

// ---- src/rfctl_drv_pin.sv ----
module rfctl_drv_pin
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset_n,
  // Carrier and modulation
  input  wire logic carrier,
  input  wire logic txModData,
  // Settings for this driver
  input  wire logic enable,
  input  wire logic invertOn,
  input  wire logic invertOff,
  input  wire logic unmodulated,
  // Pin level
  output logic      pinOut
);

  rfctl_pkg::rfctl_pin_t st;       // Current state
  rfctl_pkg::rfctl_pin_t next_st;  // Next state

  // Carrier gated by data unless unmodulated; inversion per on or off state
  always_comb
  begin
    next_st = st;
    if (enable)
    begin
      next_st.pin = (carrier & (txModData | unmodulated)) ^ invertOn;
    end
    else
    begin
      next_st.pin = invertOff;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pinOut = st.pin;

endmodule

// ---- src/rfctl_top.sv ----
// Behaviour
// [R1] Suppress mode drops streams under four bits; the code drops only those flagged frameBad
// [R2] Type B drop also needs start-frame bit
// [R3] Single mode: receiver stops after one frame
// [R4] Multi mode: receive never ends by itself
// [R5] Other command or multi clear stops receiving
// [R6] Multi mode appends error byte per frame
// [R7] Framing field selects the decoder
// [R8] Rates above 424k use active-mode coding
// [R9] Bit 7 inverts pin B when enabled
// [R10] Bit 6 inverts pin A when enabled
// [R11] Bit 5 inverts pin B when disabled
// [R12] Bit 4 inverts pin A when disabled
// [R13] Bit 3 gives pin B unmodulated carrier
// [R14] Bit 3 clear lets pin B modulate
// [R15] Guard refuses enables while field present
// [R16] Bit 1 drives modulated carrier on B
// [R17] Bit 0 drives modulated carrier on A
// [R18] Driver control at 14h, resets 80h
// [R19] Guard reads zero; field detect synchronised
//
// The implementer's own choice: the AXI4-Lite register port.
`include "rfctl_consts.svh"

module rfctl_top
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // AXI4-Lite write address
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  // AXI4-Lite write data
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read address
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  // AXI4-Lite read data
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Frame decoder side
  input  wire logic        frameEnd,
  input  wire logic        frameBad,
  input  wire logic [7:0]  frameBitCount,
  input  wire logic        rxRateAbove424,
  input  wire logic [7:0]  errorFlags,
  // Receive results
  output logic             rxEnable,
  output logic [1:0]       decoderSel,
  output logic             frameReport,
  output logic             frameDiscard,
  output logic             appendValid,
  output logic [7:0]       appendByte,
  // Analog front end
  input  wire logic        externalField,
  input  wire logic        carrier,
  input  wire logic        txModData,
  output logic             driverPinA,
  output logic             driverPinB
);

  rfctl_pkg::rfctl_state_t st;       // Current state
  rfctl_pkg::rfctl_state_t next_st;  // Next state

  logic       wrFire;      // Both write halves held, perform write
  logic       cmdWrite;    // Command register written
  logic       modeWrite;   // Receive mode register written
  logic       ctrlWrite;   // Driver control written
  logic       isShort;     // Stream shorter than four bits
  logic       typeB;       // Type B framing chosen
  logic       discard;     // Frame to be dropped silently
  logic       accept;      // Frame to be reported
  logic       multi;       // Multi-frame receive set
  logic [7:0] newCtrl;     // Driver control after guard
  logic [1:0] pinLevel;    // Driver pin levels

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  assign awready = !st.awHeld && !st.bValid;
  assign wready  = !st.wHeld && !st.bValid;
  assign arready = !st.rValid;
  assign bvalid  = st.bValid;
  assign bresp   = st.bResp;
  assign rvalid  = st.rValid;
  assign rresp   = st.rResp;
  assign rdata   = {24'h000000, st.rData};

  // Write decode, lane 0 carries every register
  assign wrFire    = st.awHeld && st.wHeld && !st.bValid;
  assign cmdWrite  = wrFire && st.wStrb0 && (st.awAddr == `RFCTL_ADDR_CMD);
  assign modeWrite = wrFire && st.wStrb0 && (st.awAddr == `RFCTL_ADDR_RXMODE);
  assign ctrlWrite = wrFire && st.wStrb0 && (st.awAddr == `RFCTL_ADDR_TXCTRL);

  // ----------------------------------------
  // Receive frame qualification
  // ----------------------------------------
  assign multi   = st.rxMode[`RFCTL_RX_MULTI];
  assign isShort = frameBitCount < `RFCTL_SHORT_BITS;
  assign typeB   = st.rxMode[1:0] == `RFCTL_FRM_TYPE_B;
  // Short bad stream dropped; type B only with start frame required
  assign discard = st.rxActive && frameEnd && frameBad && isShort  // R1
                   && st.rxMode[`RFCTL_RX_SUPPRESS]
                   && (!typeB || st.sofReq);  // R2
  assign accept  = st.rxActive && frameEnd && !discard;

  // Guarded driver control value
  always_comb
  begin
    newCtrl = st.wData;
    newCtrl[`RFCTL_TX_GUARD] = 1'b0;  // R19
    if (st.wData[`RFCTL_TX_GUARD] && st.fieldSync)
    begin
      // Enables may be cleared but not set
      newCtrl[1:0] = st.wData[1:0] & st.txCtrl[1:0];  // R15
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    // Field detect synchroniser
    next_st.fieldMeta = externalField;
    next_st.fieldSync = st.fieldMeta;  // R19
    // Capture write address
    if (awvalid && awready)
    begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = awaddr;
    end
    // Capture write data
    if (wvalid && wready)
    begin
      next_st.wHeld  = 1'b1;
      next_st.wData  = wdata[7:0];
      next_st.wStrb0 = wstrb[0];
    end
    // Write response
    if (wrFire)
    begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bValid = 1'b1;
      unique case (st.awAddr)
        `RFCTL_ADDR_CMD, `RFCTL_ADDR_SOFREQ, `RFCTL_ADDR_RXMODE, `RFCTL_ADDR_TXCTRL:
          next_st.bResp = `RFCTL_RESP_OKAY;
        default:
          next_st.bResp = `RFCTL_RESP_SLVERR;
      endcase
    end
    else if (st.bValid && bready)
    begin
      next_st.bValid = 1'b0;
    end
    // Read response
    if (arvalid && arready)
    begin
      next_st.rValid = 1'b1;
      next_st.rResp  = `RFCTL_RESP_OKAY;
      unique case (araddr)
        `RFCTL_ADDR_CMD:    next_st.rData = {4'h0, st.command};
        `RFCTL_ADDR_SOFREQ: next_st.rData = {7'h00, st.sofReq};
        `RFCTL_ADDR_RXMODE: next_st.rData = st.rxMode;
        `RFCTL_ADDR_TXCTRL: next_st.rData = st.txCtrl;
        `RFCTL_ADDR_STATUS: next_st.rData = {6'h00, st.fieldSync, st.rxActive};
        default:
        begin
          next_st.rData = 8'h00;
          next_st.rResp = `RFCTL_RESP_SLVERR;
        end
      endcase
    end
    else if (st.rValid && rready)
    begin
      next_st.rValid = 1'b0;
    end
    // Frame result pulses
    next_st.frameReport  = accept;
    next_st.frameDiscard = discard;  // R1
    next_st.appendValid  = accept && multi;  // R6
    if (accept && multi)
    begin
      next_st.appendByte = errorFlags;  // R6
    end
    // Single mode ends after one frame; multi keeps going
    if (accept && !multi)  // R4
    begin
      next_st.rxActive = 1'b0;  // R3
      next_st.command  = `RFCTL_CMD_IDLE;
    end
    // Decoder selection, high rates use active coding
    if (rxRateAbove424)
    begin
      next_st.decoderSel = `RFCTL_FRM_ACTIVE;  // R8
    end
    else
    begin
      next_st.decoderSel = st.rxMode[1:0];  // R7
    end
    // Command write
    if (cmdWrite)
    begin
      next_st.command = st.wData[3:0];
      if (st.rxActive && multi)
      begin
        // Only Receive keeps a multi-frame reception running
        next_st.rxActive = st.wData[3:0] == `RFCTL_CMD_RECEIVE;  // R5
      end
      else
      begin
        next_st.rxActive = (st.wData[3:0] == `RFCTL_CMD_RECEIVE)
                           || (st.wData[3:0] == `RFCTL_CMD_TRANSCEIVE);
      end
    end
    // Receive mode write
    if (modeWrite)
    begin
      next_st.rxMode = st.wData;
      if (!st.wData[`RFCTL_RX_MULTI] && multi && st.rxActive)
      begin
        next_st.rxActive = 1'b0;  // R5
        next_st.command  = `RFCTL_CMD_IDLE;
      end
    end
    // Start of frame required write
    if (wrFire && st.wStrb0 && (st.awAddr == `RFCTL_ADDR_SOFREQ))
    begin
      next_st.sofReq = st.wData[0];
    end
    // Driver control write
    if (ctrlWrite)
    begin
      next_st.txCtrl = newCtrl;  // R15
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st        <= '0;
      st.txCtrl <= `RFCTL_TXCTRL_RESET;  // R18
      st.rxMode <= `RFCTL_RXMODE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Driver pins
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_drv
      // Pin A is index 0, pin B index 1; only B has the carrier option
      rfctl_drv_pin u_pin
      (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .carrier     (carrier),
        .txModData   (txModData),
        .enable      (st.txCtrl[gi]),  // R16 R17
        .invertOn    (st.txCtrl[`RFCTL_TX_INV_ON_LO + gi]),  // R9 R10
        .invertOff   (st.txCtrl[`RFCTL_TX_INV_OFF_LO + gi]),  // R11 R12
        .unmodulated ((gi == 1) && st.txCtrl[`RFCTL_TX_CW_B]),  // R13 R14
        .pinOut      (pinLevel[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign driverPinA   = pinLevel[0];
  assign driverPinB   = pinLevel[1];
  assign rxEnable     = st.rxActive;
  assign decoderSel   = st.decoderSel;
  assign frameReport  = st.frameReport;
  assign frameDiscard = st.frameDiscard;
  assign appendValid  = st.appendValid;
  assign appendByte   = st.appendByte;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Short bad stream while suppressing
  sequence s_short_bad;
    st.rxActive && frameEnd && frameBad && (frameBitCount < `RFCTL_SHORT_BITS)
    && st.rxMode[`RFCTL_RX_SUPPRESS] && !cmdWrite && !modeWrite;
  endsequence

  // Good frame in multi mode with no host action
  sequence s_multi_frame;
    st.rxActive && multi && frameEnd && !frameBad && !cmdWrite && !modeWrite;
  endsequence

  a_short_dropped: assert property ( // R1
    s_short_bad and (st.rxMode[1:0] != `RFCTL_FRM_TYPE_B)
    |=> !frameReport && frameDiscard && rxEnable)
    else $error("short stream was not dropped");

  a_type_b_needs_sof: assert property ( // R2
    s_short_bad and (st.rxMode[1:0] == `RFCTL_FRM_TYPE_B) and !st.sofReq
    |=> frameReport && !frameDiscard)
    else $error("type B stream dropped without start frame bit");

  a_single_stops: assert property ( // R3
    st.rxActive && !multi && frameEnd && !frameBad && !cmdWrite
    |=> !rxEnable && frameReport)
    else $error("single mode receiver stayed on");

  a_multi_stays: assert property ( // R4
    s_multi_frame |=> rxEnable && frameReport)
    else $error("multi mode receiver stopped on its own");

  a_multi_clear_stop: assert property ( // R5
    st.rxActive && multi && modeWrite && !st.wData[`RFCTL_RX_MULTI] && !cmdWrite
    |=> !rxEnable)
    else $error("clearing multi bit did not stop reception");

  a_error_byte: assert property ( // R6
    s_multi_frame |=> appendValid && (appendByte == $past(errorFlags)))
    else $error("error byte not appended");

  a_framing_sel: assert property ( // R7
    !rxRateAbove424 |=> decoderSel == $past(st.rxMode[1:0]))
    else $error("decoder does not follow framing field");

  a_high_rate: assert property ( // R8
    rxRateAbove424 |=> decoderSel == `RFCTL_FRM_ACTIVE)
    else $error("high rate not using active coding");

  a_pin_b_on: assert property ( // R9
    st.txCtrl[`RFCTL_TX_EN_B] |=> driverPinB == (($past(carrier)
    & ($past(txModData) | $past(st.txCtrl[`RFCTL_TX_CW_B]))) ^ $past(st.txCtrl[7])))
    else $error("pin B enabled level wrong");

  a_pin_a_on: assert property ( // R10
    st.txCtrl[`RFCTL_TX_EN_A] |=> driverPinA == (($past(carrier)
    & $past(txModData)) ^ $past(st.txCtrl[6])))
    else $error("pin A enabled level wrong");

  a_pin_b_off: assert property ( // R11
    !st.txCtrl[`RFCTL_TX_EN_B] |=> driverPinB == $past(st.txCtrl[5]))
    else $error("pin B disabled level wrong");

  a_pin_a_off: assert property ( // R12
    !st.txCtrl[`RFCTL_TX_EN_A] |=> driverPinA == $past(st.txCtrl[4]))
    else $error("pin A disabled level wrong");

  a_guard_refuse: assert property ( // R15
    ctrlWrite && st.wData[`RFCTL_TX_GUARD] && st.fieldSync && !st.txCtrl[0]
    |=> !st.txCtrl[`RFCTL_TX_EN_A])
    else $error("driver enabled despite external field");

  a_guard_reads_zero: assert property ( // R19
    arvalid && arready && (araddr == `RFCTL_ADDR_TXCTRL)
    |=> rvalid && !rdata[`RFCTL_TX_GUARD])
    else $error("guard bit read back as one");

endmodule

// ---- testbench/rfctl_partner.sv ----
module rfctl_partner
(
  // Clock
  input  wire logic  ref_clk,
  // Front end outputs
  output logic       carrier,
  output logic       txModData,
  output logic       externalField,
  output logic       rxRateAbove424,
  // Decoder outputs
  output logic       frameEnd,
  output logic       frameBad,
  output logic [7:0] frameBitCount,
  output logic [7:0] errorFlags
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Carrier and envelope
  // ----------------------------------------
  logic [2:0] phase;  // Envelope pattern step

  initial
  begin
    {carrier, txModData, externalField, rxRateAbove424} = 4'h0;
    {frameEnd, frameBad, frameBitCount, errorFlags} = 18'h00000;
    phase = 3'h0;
  end

  // Carrier flips every cycle, envelope every two
  always @(posedge ref_clk)
  begin
    phase <= phase + 3'h1;
    carrier <= ~carrier;
    txModData <= phase[1];
  end

  // ----------------------------------------
  // Commanded events
  // ----------------------------------------
  // Sets the field detector level
  task automatic setField(input logic v);
  begin
    @(posedge ref_clk);
    externalField <= v;
  end
  endtask

  // Sets the high rate indication
  task automatic setRate(input logic v);
  begin
    @(posedge ref_clk);
    rxRateAbove424 <= v;
  end
  endtask

  // One stream end; qualifiers go stale afterwards
  task automatic sendFrame(input logic bad, input logic [7:0] cnt);
  begin
    @(posedge ref_clk);
    frameEnd <= 1'b1;
    frameBad <= bad;
    frameBitCount <= cnt;
    errorFlags <= cnt ^ 8'h3C;
    @(posedge ref_clk);
    frameEnd <= 1'b0;
    frameBad <= ~bad;
    frameBitCount <= ~cnt;
  end
  endtask
endmodule

// ---- testbench/rfctl_top_bench.sv ----
`include "rfctl_consts.svh"

module rfctl_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        ref_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rxEnable, frameReport, frameDiscard;
  logic        appendValid, externalField, carrier, txModData, driverPinA, driverPinB;
  logic        frameEnd, frameBad, rxRateAbove424;
  logic [7:0]  awaddr, araddr, frameBitCount, errorFlags, appendByte;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, decoderSel, resp;
  int          n_fail, tests_run;

  // Design and far side
  rfctl_top u_rfctl_top (.*);
  rfctl_partner u_rfctl_partner (.ref_clk(ref_clk), .carrier(carrier),
    .txModData(txModData), .externalField(externalField),
    .rxRateAbove424(rxRateAbove424), .frameEnd(frameEnd), .frameBad(frameBad),
    .frameBitCount(frameBitCount), .errorFlags(errorFlags));

  // 50 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Compare and bus tasks
  // ----------------------------------------
  task automatic chkBit(input logic got, input logic exp, input string msg);
  begin
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t %s got %b exp %b", $time, msg, got, exp);
    end
  end
  endtask

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string msg);
  begin
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  end
  endtask

  // Write: each half released at the rising edge that takes it
  task automatic axiWr(input logic [7:0] a, input logic [7:0] d);
    logic b;
  begin
    b = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!b)
    begin
      @(posedge ref_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      b = bvalid;
      resp = bresp;
    end
    bready <= 1'b0;
  end
  endtask

  // Read with expected data and response
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic v;
    logic [7:0] d;
  begin
    v = 1'b0;
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!v)
    begin
      @(posedge ref_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      v = rvalid;
      d = rdata[7:0];
      resp = rresp;
    end
    rready <= 1'b0;
    chkByte(d, exp, "read data");
    chkByte({6'h00, resp}, {6'h00, er}, "read resp");
  end
  endtask

  // Pins follow the previous cycle's carrier and envelope
  task automatic pinChk(input logic [7:0] c);
    logic cr, md;
  begin
    @(posedge ref_clk);
    #1;
    {cr, md} = {carrier, txModData};
    repeat (6)
    begin
      @(posedge ref_clk);
      #1;
      chkBit(driverPinA, c[0] ? (cr & md) ^ c[6] : c[4], "pin A");
      chkBit(driverPinB, c[1] ? (cr & (md | c[3])) ^ c[7] : c[5], "pin B");
      {cr, md} = {carrier, txModData};
    end
  end
  endtask

  // Arms the receiver in a given mode
  task automatic armRx(input logic [7:0] mode);
  begin
    axiWr(`RFCTL_ADDR_RXMODE, mode);
    axiWr(`RFCTL_ADDR_CMD, 8'h08);
    chkBit(rxEnable, 1'b1, "armed");
  end
  endtask

  // One stream end and the expected outcome
  task automatic frm(input logic bad, input logic [7:0] n, input logic [3:0] e);
  begin
    u_rfctl_partner.sendFrame(bad, n);
    #1;
    chkBit(frameReport, e[3], "report");
    chkBit(frameDiscard, e[2], "discard");
    chkBit(rxEnable, e[1], "rx on");
    chkBit(appendValid, e[0], "append");
    if (e[0])
      chkByte(appendByte, n ^ 8'h3C, "error byte");
  end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tReset;
  begin
    rdChk(`RFCTL_ADDR_TXCTRL, 8'h80, `RFCTL_RESP_OKAY);
    chkBit(driverPinA | driverPinB, 1'b0, "pins off");
    rdChk(8'h1C, 8'h00, `RFCTL_RESP_SLVERR);
    axiWr(`RFCTL_ADDR_STATUS, 8'hFF);
    chkByte({6'h00, resp}, 8'h02, "ro write");
    $display("Test done: reset");
  end
  endtask

  task automatic tDrivers;
    logic [7:0] ctl [5];
  begin
    ctl = '{8'h80, 8'h83, 8'h4B, 8'h30, 8'hC3};
    foreach (ctl[i])
    begin
      axiWr(`RFCTL_ADDR_TXCTRL, ctl[i]);
      pinChk(ctl[i]);
    end
    $display("Test done: drivers");
  end
  endtask

  task automatic tGuard;
  begin
    axiWr(`RFCTL_ADDR_TXCTRL, 8'h80);
    u_rfctl_partner.setField(1'b1);
    repeat (3) @(posedge ref_clk);
    rdChk(`RFCTL_ADDR_STATUS, 8'h02, `RFCTL_RESP_OKAY);
    axiWr(`RFCTL_ADDR_TXCTRL, 8'h87);
    rdChk(`RFCTL_ADDR_TXCTRL, 8'h80, `RFCTL_RESP_OKAY);
    axiWr(`RFCTL_ADDR_TXCTRL, 8'h83);
    axiWr(`RFCTL_ADDR_TXCTRL, 8'h84);
    rdChk(`RFCTL_ADDR_TXCTRL, 8'h80, `RFCTL_RESP_OKAY);
    u_rfctl_partner.setField(1'b0);
    repeat (3) @(posedge ref_clk);
    axiWr(`RFCTL_ADDR_TXCTRL, 8'h87);
    rdChk(`RFCTL_ADDR_TXCTRL, 8'h83, `RFCTL_RESP_OKAY);
    $display("Test done: guard");
  end
  endtask

  task automatic tReceive;
  begin
    armRx(8'h00);
    frm(1'b0, 8'h08, 4'h8);
    armRx(8'h08);
    frm(1'b1, 8'h03, 4'h6);
    frm(1'b1, 8'h04, 4'h8);
    armRx(8'h0B);
    frm(1'b1, 8'h03, 4'h8);
    axiWr(`RFCTL_ADDR_SOFREQ, 8'h01);
    armRx(8'h0B);
    frm(1'b1, 8'h03, 4'h6);
    axiWr(`RFCTL_ADDR_CMD, 8'h00);
    $display("Test done: receive");
  end
  endtask

  task automatic tMulti;
  begin
    armRx(8'h04);
    frm(1'b0, 8'h10, 4'hB);
    frm(1'b1, 8'h02, 4'hB);
    axiWr(`RFCTL_ADDR_CMD, 8'h08);
    chkBit(rxEnable, 1'b1, "receive kept");
    axiWr(`RFCTL_ADDR_CMD, 8'h00);
    chkBit(rxEnable, 1'b0, "stop by cmd");
    armRx(8'h04);
    axiWr(`RFCTL_ADDR_RXMODE, 8'h00);
    chkBit(rxEnable, 1'b0, "stop by bit");
    axiWr(`RFCTL_ADDR_RXMODE, 8'h04);
    axiWr(`RFCTL_ADDR_CMD, 8'h0C);
    chkBit(rxEnable, 1'b1, "transceive armed");
    frm(1'b0, 8'h20, 4'hB);
    axiWr(`RFCTL_ADDR_CMD, 8'h0C);
    chkBit(rxEnable, 1'b0, "stop by other cmd");
    $display("Test done: multi");
  end
  endtask

  task automatic tDecoder;
  begin
    for (int i = 0; i < 4; i++)
    begin
      axiWr(`RFCTL_ADDR_RXMODE, 8'(i));
      #1;
      chkByte({6'h00, decoderSel}, 8'(i), "decoder");
    end
    u_rfctl_partner.setRate(1'b1);
    repeat (2) @(posedge ref_clk);
    #1;
    chkByte({6'h00, decoderSel}, 8'h01, "fast coding");
    u_rfctl_partner.setRate(1'b0);
    $display("Test done: decoder");
  end
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic wrap_up;
  begin
    $display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  // Main sequence
  initial
  begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    n_fail = 0;
    tests_run = 0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    tReset();
    tDrivers();
    tGuard();
    tReceive();
    tMulti();
    tDecoder();
    wrap_up();
  end

  // Watchdog, well past the expected run length
  initial
  begin
    #200us;
    n_fail++;
    wrap_up();
  end
endmodule
